/* File: verilog/dtmfq_pkg.sv */
package dtmfq_pkg;

    // ************************************************************
    // clock and tick base
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    // ************************************************************
    // qualification times, as printed, and in ticks
    // ************************************************************
    localparam int QUAL_STD_MS = 41;
    localparam int QUAL_SHORT_MS = 26;
    localparam int BREAK_QUAL_US = 400;
    localparam int HOLD_STD_MS = 28;
    localparam int HOLD_SHORT_MS = 20;
    localparam int SP_DELAY_US = 600;
    localparam int MIN_STD_MS = 24;
    localparam int MIN_SHORT_MS = 10;

    localparam int CNT_W = 10;
    typedef logic [CNT_W-1:0] dtmfq_cnt_t;

    localparam dtmfq_cnt_t QUAL_STD_T = CNT_W'(QUAL_STD_MS * 1000 / TICK_US);
    localparam dtmfq_cnt_t QUAL_SHORT_T = CNT_W'(QUAL_SHORT_MS * 1000 / TICK_US);
    localparam dtmfq_cnt_t BREAK_QUAL_T = CNT_W'(BREAK_QUAL_US / TICK_US);
    localparam dtmfq_cnt_t HOLD_STD_T = CNT_W'(HOLD_STD_MS * 1000 / TICK_US);
    localparam dtmfq_cnt_t HOLD_SHORT_T = CNT_W'(HOLD_SHORT_MS * 1000 / TICK_US);
    localparam dtmfq_cnt_t SP_DELAY_T = CNT_W'(SP_DELAY_US / TICK_US);
    localparam dtmfq_cnt_t MIN_STD_T = CNT_W'(MIN_STD_MS * 1000 / TICK_US);
    localparam dtmfq_cnt_t MIN_SHORT_T = CNT_W'(MIN_SHORT_MS * 1000 / TICK_US);
    localparam dtmfq_cnt_t CNT_ONE = 10'h001;
    localparam dtmfq_cnt_t CNT_ZERO = 10'h000;

    // ************************************************************
    // digit code and states
    // ************************************************************
    localparam int CODE_W = 4;
    localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_QUAL = 2'b01,
        ST_CODE = 2'b10,
        ST_VALID = 2'b11
    } dtmfq_state_e;

endpackage

/* File: verilog/dtmfq_qualifier.sv */
`timescale 1ns/1ps
// Summary of operation
// - accept tone persisting 49 ms / 37 ms
// - ignore tones shorter than 24 ms / 10 ms
// - clear code and strobe after quiet gap
// - short gap digit change keeps strobe high
// - dropouts under 0.4 ms ignored while qualifying
// - dropouts under 10/3 ms ignored when valid
// - code appears 41 ms / 26 ms after onset
// - withdraw outputs 28 ms / 20 ms after tone
// - strobe rises 0.6 ms after code appears
module dtmfq_qualifier #(
    parameter int TICK_CYCLES = dtmfq_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic tone_i,
    input wire logic [dtmfq_pkg::CODE_W-1:0] tone_code_i,
    input wire logic short_mode_i,
    output logic [dtmfq_pkg::CODE_W-1:0] digit_code_o,
    output logic tone_valid_strobe_o
);

    // ************************************************************
    // tick divider
    // ************************************************************
    localparam int DIV_W = $clog2(TICK_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] next_div;
    logic tick;

    // one 0.1 ms enable pulse; all timers count in these ticks
    always_comb begin
        tick = (div == DIV_LAST);
        next_div = tick ? DIV_ZERO : DIV_W'(div + 1'b1);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div <= DIV_ZERO;
        end else begin
            div <= next_div;
        end
    end

    // ************************************************************
    // qualification state machine
    // ************************************************************
    dtmfq_pkg::dtmfq_state_e state;
    dtmfq_pkg::dtmfq_state_e next_state;
    dtmfq_pkg::dtmfq_cnt_t run;
    dtmfq_pkg::dtmfq_cnt_t next_run;
    dtmfq_pkg::dtmfq_cnt_t gap;
    dtmfq_pkg::dtmfq_cnt_t next_gap;
    logic [dtmfq_pkg::CODE_W-1:0] code;
    logic [dtmfq_pkg::CODE_W-1:0] next_code;
    logic strobe;
    logic next_strobe;
    dtmfq_pkg::dtmfq_cnt_t qual_t;
    dtmfq_pkg::dtmfq_cnt_t hold_t;
    dtmfq_pkg::dtmfq_cnt_t run_inc;
    dtmfq_pkg::dtmfq_cnt_t gap_inc;

    // mode picks the timing set; a mode change mid-digit applies at once
    always_comb begin
        qual_t = short_mode_i ? dtmfq_pkg::QUAL_SHORT_T : dtmfq_pkg::QUAL_STD_T;
        hold_t = short_mode_i ? dtmfq_pkg::HOLD_SHORT_T : dtmfq_pkg::HOLD_STD_T;
        run_inc = run + dtmfq_pkg::CNT_ONE;
        gap_inc = gap + dtmfq_pkg::CNT_ONE;
        next_state = state;
        next_run = run;
        next_gap = gap;
        next_code = code;
        next_strobe = strobe;
        // gap measures the present dropout; any tone cycle restarts it
        if (tone_i) begin
            next_gap = dtmfq_pkg::CNT_ZERO;
        end else if (tick) begin
            next_gap = gap_inc;
        end
        unique case (state)
            dtmfq_pkg::ST_IDLE: begin
                next_run = dtmfq_pkg::CNT_ZERO;
                next_gap = dtmfq_pkg::CNT_ZERO;
                if (tone_i) begin
                    next_state = dtmfq_pkg::ST_QUAL;
                end
            end
            dtmfq_pkg::ST_QUAL: begin
                if (tick) begin
                    next_run = run_inc;
                    // leave only on the tick after the gap has counted the full 0.4 ms:
                    // a dropout just under 0.4 ms can still straddle that many ticks
                    if (!tone_i && gap >= dtmfq_pkg::BREAK_QUAL_T) begin
                        next_state = dtmfq_pkg::ST_IDLE;
                    end else if (run_inc >= qual_t) begin
                        next_state = dtmfq_pkg::ST_CODE;
                        next_code = tone_code_i;
                        next_run = dtmfq_pkg::CNT_ZERO;
                    end
                end
            end
            dtmfq_pkg::ST_CODE, dtmfq_pkg::ST_VALID: begin
                if (tick && !tone_i && gap_inc >= hold_t) begin
                    // long quiet withdraws both outputs together
                    next_state = dtmfq_pkg::ST_IDLE;
                    next_code = dtmfq_pkg::CODE_RESET;
                    next_strobe = 1'b0;
                end else if (state == dtmfq_pkg::ST_CODE && tick) begin
                    next_run = run_inc;
                    if (run_inc >= dtmfq_pkg::SP_DELAY_T) begin
                        next_state = dtmfq_pkg::ST_VALID;
                        next_strobe = 1'b1;
                    end
                end
                // shorter dropouts and new digits leave code untouched
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= dtmfq_pkg::ST_IDLE;
            run <= dtmfq_pkg::CNT_ZERO;
            gap <= dtmfq_pkg::CNT_ZERO;
            code <= dtmfq_pkg::CODE_RESET;
            strobe <= 1'b0;
        end else begin
            state <= next_state;
            run <= next_run;
            gap <= next_gap;
            code <= next_code;
            strobe <= next_strobe;
        end
    end

    // code is latched one state ahead so it is stable when the strobe rises
    assign digit_code_o = code;
    assign tone_valid_strobe_o = strobe;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_code_shown;
        state == dtmfq_pkg::ST_CODE && !strobe;
    endsequence

    sequence s_strobe_up;
        $rose(strobe) && $stable(code);
    endsequence

    property p_idle_quiet;
        state == dtmfq_pkg::ST_IDLE |-> !strobe && code == dtmfq_pkg::CODE_RESET;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle outputs not clear");

    property p_qual_time;
        state == dtmfq_pkg::ST_QUAL && next_state == dtmfq_pkg::ST_CODE
            |-> run_inc == qual_t;
    endproperty
    a_qual_time: assert property (p_qual_time) else $error("qualified at wrong time");

    property p_min_time;
        state == dtmfq_pkg::ST_QUAL && next_state == dtmfq_pkg::ST_CODE
            |-> run_inc >= (short_mode_i ? dtmfq_pkg::MIN_SHORT_T : dtmfq_pkg::MIN_STD_T);
    endproperty
    a_min_time: assert property (p_min_time) else $error("short tone qualified");

    property p_break_qual;
        state == dtmfq_pkg::ST_QUAL && next_state == dtmfq_pkg::ST_IDLE
            |-> tick && gap == dtmfq_pkg::BREAK_QUAL_T;
    endproperty
    a_break_qual: assert property (p_break_qual) else $error("dropout cut qualification");

    property p_hold_clear;
        state == dtmfq_pkg::ST_VALID && next_state == dtmfq_pkg::ST_IDLE
            |-> !tone_i && gap_inc == hold_t ##1 !strobe && code == dtmfq_pkg::CODE_RESET;
    endproperty
    a_hold_clear: assert property (p_hold_clear) else $error("hold clear wrong");

    property p_short_drop;
        strobe && gap_inc < hold_t |=> strobe;
    endproperty
    a_short_drop: assert property (p_short_drop) else $error("strobe lost on dropout");

    property p_code_steady;
        strobe && $past(strobe) |-> $stable(code);
    endproperty
    a_code_steady: assert property (p_code_steady) else $error("code changed while valid");

    // the code-to-strobe wait is thousands of clocks at full rate, so it is
    // bounded through the run counter rather than a long delay range
    property p_strobe_delay;
        s_code_shown ##0 (next_state == dtmfq_pkg::ST_VALID) |=> s_strobe_up;
    endproperty
    a_strobe_delay: assert property (p_strobe_delay) else $error("strobe delay wrong");

    // run counts ticks since the code appeared; it must not pass the strobe delay
    property p_code_age;
        s_code_shown |-> run < dtmfq_pkg::SP_DELAY_T;
    endproperty
    a_code_age: assert property (p_code_age) else $error("strobe late after code");

    property p_strobe_cause;
        $rose(strobe) |-> $past(state) == dtmfq_pkg::ST_CODE
            && $past(run_inc) == dtmfq_pkg::SP_DELAY_T;
    endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("strobe rose early");

    // while code or strobe is shown, the quiet count never reaches the hold time:
    // the clear must take effect on the very tick that would get there
    property p_quiet_clears;
        state != dtmfq_pkg::ST_IDLE && state != dtmfq_pkg::ST_QUAL
            |-> gap < hold_t;
    endproperty
    a_quiet_clears: assert property (p_quiet_clears) else $error("quiet did not clear");

endmodule

/* File: verif/dtmfq_host_model.sv */
`timescale 1ns/1ps
// ****************
// host side: takes the digit code on the strobe rising edge
// ****************
module dtmfq_host_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [dtmfq_pkg::CODE_W-1:0] code_i,
    input wire logic strobe_i,
    output logic [dtmfq_pkg::CODE_W-1:0] latched_o
);
    logic strobe_q;

    // edge latch, not level: the code is only promised stable once the strobe rises
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strobe_q <= 1'b0;
            latched_o <= 4'h0;
        end else begin
            strobe_q <= strobe_i;
            if (strobe_i && !strobe_q) begin
                latched_o <= code_i;
            end
        end
    end
endmodule

/* File: verif/dtmf_receive_qualifier_test.sv */
`timescale 1ns/1ps
module dtmf_receive_qualifier_test;
    // ****************
    // one ms is 40 cycles with a 4-cycle tick
    // ****************
    localparam int MS = 40;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic tone_i = 1'b0;
    logic [dtmfq_pkg::CODE_W-1:0] tone_code_i = 4'h0;
    logic short_mode_i = 1'b0;
    logic [dtmfq_pkg::CODE_W-1:0] digit_code_o;
    logic [dtmfq_pkg::CODE_W-1:0] latched;
    logic tone_valid_strobe_o;
    int errors = 0;
    int checks = 0;
    int n;
    // printed limits per mode: index 0 standard, 1 short
    int qlo[2] = '{24, 12};
    int qhi[2] = '{49, 37};
    int qtyp[2] = '{41, 26};
    int hlo[2] = '{24, 15};
    int hhi[2] = '{35, 27};
    int slim[2] = '{24, 10};
    int brk[2] = '{10, 3};

    dtmfq_qualifier #(.TICK_CYCLES(4)) i_dtmfq_qualifier (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .tone_i(tone_i), .tone_code_i(tone_code_i), .short_mode_i(short_mode_i),
        .digit_code_o(digit_code_o), .tone_valid_strobe_o(tone_valid_strobe_o));
    dtmfq_host_model i_dtmfq_host_model (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .code_i(digit_code_o), .strobe_i(tone_valid_strobe_o), .latched_o(latched));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic set(input logic on, input logic [3:0] code);
        @(posedge clk_i);
        tone_i <= on;
        tone_code_i <= code;
    endtask

    // bounded wait for strobe (sel 0) or a nonzero code (sel 1) to become want
    task automatic wait_for(input bit sel, input bit want, input int lo, input int hi);
        n = 0;
        while ((sel ? (digit_code_o !== 4'h0) : (tone_valid_strobe_o === 1'b1)) != want) begin
            @(posedge clk_i);
            n++;
            if (n > hi) begin
                chk(1'b0, "wait ran out");
                end_of_test();
            end
        end
        chk(n >= lo, "event came too early");
    endtask

    // outputs must hold one value for the whole span; one miss is counted once
    task automatic steady(input logic [3:0] c, input logic s, input int cyc, input string msg);
        bit bad;
        bad = 1'b0;
        repeat (cyc) begin
            @(posedge clk_i);
            if (digit_code_o !== c || tone_valid_strobe_o !== s) bad = 1'b1;
        end
        chk(!bad, msg);
    endtask

    task automatic t_accept(input int m);
        set(1'b1, 4'hA);
        wait_for(1'b1, 1'b1, qlo[m] * MS, qhi[m] * MS + 8);
        chk(digit_code_o === 4'hA && tone_valid_strobe_o === 1'b0, "code before strobe");
        wait_for(1'b0, 1'b1, 8, MS + 4);
        // the host takes the code on the edge after it sees the rise
        @(posedge clk_i);
        chk(latched === 4'hA, "host latch");
        set(1'b0, 4'h0);
        wait_for(1'b0, 1'b0, hlo[m] * MS, hhi[m] * MS + 8);
        chk(digit_code_o === 4'h0, "code not cleared with strobe");
        steady(4'h0, 1'b0, 120 * MS, "idle after hold");
    endtask

    task automatic t_short(input int m);
        set(1'b1, 4'h3);
        repeat (slim[m] * MS - MS) @(posedge clk_i);
        set(1'b0, 4'h0);
        steady(4'h0, 1'b0, 60 * MS, "short tone gave output");
    endtask

    task automatic t_drop(input int m);
        set(1'b1, 4'h5);
        repeat (10 * MS) @(posedge clk_i);
        set(1'b0, 4'h5);
        repeat (10) @(posedge clk_i);
        set(1'b1, 4'h5);
        // a restarted qualification would need the whole typical delay again
        wait_for(1'b0, 1'b1, 0, (qtyp[m] - 8) * MS);
        chk(digit_code_o === 4'h5, "code after dropout");
        set(1'b1, 4'h9);
        steady(4'h5, 1'b1, 5 * MS, "digit change");
        chk(latched === 4'h5, "host latch after dropout");
        set(1'b0, 4'h9);
        steady(4'h5, 1'b1, brk[m] * MS - MS / 2, "dropout while valid");
        set(1'b1, 4'h9);
        steady(4'h5, 1'b1, MS, "tone back");
        set(1'b0, 4'h0);
        wait_for(1'b0, 1'b0, hlo[m] * MS, hhi[m] * MS + 8);
        steady(4'h0, 1'b0, 120 * MS, "idle after hold");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        chk(digit_code_o === 4'h0 && tone_valid_strobe_o === 1'b0, "reset state");
        arst_n_i <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_i);
            short_mode_i <= m[0];
            t_accept(m);
            t_short(m);
            t_drop(m);
        end
        end_of_test();
    end
endmodule
